// ### dv/fpm_array_model.sv
// flash array model with page erase
module fpm_array_model (
  // clock
  input  wire logic        clk,
  // read side
  input  wire logic        arrayRdEn,
  input  wire logic [1:0]  arrayRdSpace,
  input  wire logic [15:0] arrayRdAddr,
  output logic      [7:0]  arrayRdData,
  // program side
  input  wire logic        arrayWrEn,
  input  wire logic        arrayEraseEn,
  input  wire logic [1:0]  arraySpace,
  input  wire logic [15:0] arrayAddr,
  input  wire logic [7:0]  arrayWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem[logic [17:0]];
  function automatic logic [7:0] ival(input logic [1:0] s, input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ {s, 6'h2B};
  endfunction
  initial arrayRdData = 8'h00;
  // data flips after one cycle to catch late samples
  always @(posedge clk)
  begin
    if (arrayRdEn)
      arrayRdData <= mem.exists({arrayRdSpace, arrayRdAddr}) ?
        mem[{arrayRdSpace, arrayRdAddr}] : ival(arrayRdSpace, arrayRdAddr);
    else
      arrayRdData <= ~arrayRdData;
    if (arrayEraseEn)
      for (int i = 0; i < 128; i++)
        mem[{arraySpace, arrayAddr[15:7], 7'(i)}] = 8'hFF;
    // stored as given: a missing merge shows
    if (arrayWrEn)
      mem[{arraySpace, arrayAddr}] = arrayWrData;
  end
endmodule  // fpm_array_model

// ### dv/fpm_props.sv
// checker: port properties of the flash mapper
module fpm_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // register write side
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrite,
  // cpu and code read
  input wire logic        execInternal,
  input wire logic        cpuIdle,
  input wire logic        irqDefer,
  input wire logic        codeRdReq,
  input wire logic        codeRdValid,
  input wire logic [7:0]  codeRdData,
  // data writes and array
  input wire logic        xWrReq,
  input wire logic [15:0] xWrAddr,
  input wire logic        extRamWr,
  input wire logic        intRamWr,
  input wire logic [15:0] ramWrAddr,
  input wire logic        arrayWrEn,
  input wire logic        arrayEraseEn,
  input wire logic [15:0] arrayAddr
);
  logic pbSel_reg;
  logic extSel_reg;
  wire  goWr = regWrite && regAddr == fpm_pkg::OFF_FCTL && regWrData[7:4] == fpm_pkg::KEY_GO;
  // select-bit shadows from the ports
  always_ff @(posedge clk)
  begin
    if (reset)
      pbSel_reg <= 1'b0;
    else if (regWrite && regAddr == fpm_pkg::OFF_FCTL)
      pbSel_reg <= regWrData[fpm_pkg::FCTL_PBSEL];
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      extSel_reg <= 1'b0;
    else if (regWrite && regAddr == fpm_pkg::OFF_AUXCFG)
      extSel_reg <= regWrData[fpm_pkg::AUXCFG_EXTERNAL_RAM_SELECT];
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  defer_tracks_idle_a: assert property (irqDefer == cpuIdle)
    else $error("defer not idle");
  code_read_lat_a: assert property (codeRdReq |-> ##3 codeRdValid)
    else $error("no read answer");
  valid_has_cause_a: assert property (codeRdValid |-> $past(codeRdReq, 3))
    else $error("stray answer");
  busy_read_blank_a: assert property (codeRdReq && cpuIdle |-> ##3 codeRdData == 8'hFF)
    else $error("busy read not blank");
  idle_from_go_a: assert property ($rose(cpuIdle) |-> $past(goWr && execInternal))
    else $error("stray idle");
  ext_keeps_run_a: assert property (goWr && !execInternal |=> !cpuIdle)
    else $error("external stall");
  idle_ends_a: assert property ($rose(cpuIdle) |-> ##[1:600] !cpuIdle)
    else $error("idle stuck");
  buf_no_fwd_a: assert property (xWrReq && pbSel_reg |=> !extRamWr && !intRamWr)
    else $error("buffer forwarded");
  ram_fwd_a: assert property (xWrReq && !pbSel_reg |=> extRamWr == extSel_reg
    && intRamWr == !extSel_reg && ramWrAddr == $past(xWrAddr))
    else $error("bad forward");
  erase_page_a: assert property (arrayEraseEn |-> arrayAddr[6:0] == 7'h00 && !arrayWrEn)
    else $error("erase off page base");
  cover property ($rose(cpuIdle));
  cover property (arrayEraseEn);
  cover property (codeRdValid && codeRdData != 8'hFF);
endmodule  // fpm_props

// ### dv/fpm_tb.sv
// testbench top: self-checking sequence
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, brownOut = 1'b0;
  logic execInternal = 1'b0, instrStart = 1'b0, codeRdReq = 1'b0, xWrReq = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, xWrData = 8'h00, regRdData, got;
  logic [15:0] codeRdAddr = 16'h0000, xWrAddr = 16'h0000, ramWrAddr, arrayRdAddr, arrayAddr;
  logic [7:0] codeRdData, ramWrData, arrayRdData, arrayWrData;
  logic [1:0] arrayRdSpace, arraySpace;
  logic cpuIdle, irqDefer, irq, codeRdValid, extRamWr, intRamWr, arrayRdEn, arrayWrEn;
  logic arrayEraseEn;
  logic [25:0] fw;
  logic [31:0] seed = 32'h5e07_1fde, r;
  logic [7:0] em[logic [17:0]];
  logic [15:0] bnd[10] = '{16'h0000, 16'h007F, 16'h0080, 16'h00FF, 16'h0100, 16'h01FF,
    16'h0200, 16'h027F, 16'h0280, 16'hFFFF};
  logic [23:0] acc[10] = '{24'h01_FF40, 24'h00_FE0E, 24'h02_FF02, 24'h04_FF03, 24'h05_FF00,
    24'h03_FF00, 24'h00_0000, 24'h01_0000, 24'h02_0000, 24'h04_0000};
  int errorCnt = 0, compares = 0;
  always #4 clk = ~clk;
  fpm_flash_program_mapper #(.PROG_CYCLES(16'h0002), .ERASE_CYCLES(16'h0004)) uut (.clk,
    .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .execInternal, .instrStart,
    .cpuIdle, .irqDefer, .irq, .codeRdReq, .codeRdAddr, .codeRdValid, .codeRdData, .xWrReq,
    .xWrAddr, .xWrData, .extRamWr, .intRamWr, .ramWrAddr, .ramWrData, .arrayRdEn,
    .arrayRdSpace, .arrayRdAddr, .arrayRdData, .arrayWrEn, .arrayEraseEn, .arraySpace,
    .arrayAddr, .arrayWrData, .brownOut);
  fpm_array_model pm (.clk, .arrayRdEn, .arrayRdSpace, .arrayRdAddr, .arrayRdData, .arrayWrEn,
    .arrayEraseEn, .arraySpace, .arrayAddr, .arrayWrData);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected code read: blank outside the space
  function automatic logic [7:0] ev(input logic [1:0] s, input logic [15:0] a);
    if (s == 2'b11 || (s == 2'b01 && a >= 16'h0280) || (s == 2'b10 && a >= 16'h0100))
      return 8'hFF;
    return em.exists({s, a}) ? em[{s, a}] : pm.ival(s, a);
  endfunction
  task automatic close_out();
    if (errorCnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errorCnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // an idle cycle follows each strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s = 1'b0);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    instrStart <= s;
    @(posedge clk);
    regWrite <= 1'b0;
    instrStart <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    d = regRdData;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a, got);
    chk("regRdData", 32'(e), 32'(got));
  endtask
  task automatic crc(input logic [15:0] a, input logic [7:0] e);
    codeRdReq <= 1'b1;
    codeRdAddr <= a;
    @(posedge clk);
    codeRdReq <= 1'b0;
    repeat (3) @(posedge clk);
    chk("codeRdData", {23'h0, codeRdValid, e}, {23'h0, 1'b1, codeRdData});
  endtask
  task automatic xw(input logic [15:0] a, input logic [7:0] d);
    xWrReq <= 1'b1;
    xWrAddr <= a;
    xWrData <= d;
    @(posedge clk);
    xWrReq <= 1'b0;
    @(posedge clk);
    fw = {extRamWr, intRamWr, ramWrAddr, ramWrData};
  endtask
  task automatic prog(input logic [1:0] sp, input logic ae, ei, bo);
    logic [15:0] pg, a;
    logic [7:0] d[64];
    logic [63:0] ld;
    r = rnd();
    pg = {r[15:6], 6'h00} & (sp == 2'b00 ? 16'hFFFF : (sp == 2'b01 ? 16'h01FF : 16'h007F));
    ld = {rnd(), rnd()} | 64'h8000_0000_0000_0001;
    wr(8'h03, 8'h03);
    wr(8'h01, {1'b0, ae, 6'h00});
    wr(8'h00, 8'h08);
    for (int i = 0; i < 64; i++)
    begin
      d[i] = 8'(rnd());
      if (ld[i])
        xw(pg | 16'(i), d[i]);
    end
    xw(pg | 16'h003F, ~d[63]);
    chk("bufFwd", 32'h0, 32'(fw[25:24]));
    execInternal <= ei;
    wr(8'h00, {fpm_pkg::KEY_ARM, 1'b0, sp, 1'b0});
    wr(8'h00, {fpm_pkg::KEY_GO, 1'b0, sp, 1'b0}, 1'b1);
    chk("cpuIdle", 32'(ei), 32'(cpuIdle));
    brownOut <= bo;
    got = 8'h01;
    for (int i = 0; i < 400 && got[0] === 1'b1; i++)
      rd(8'h00, got);
    chk("fctl", {29'h0, sp, 1'b0}, 32'(got));
    chk("cpuIdle", 32'h0, 32'(cpuIdle));
    brownOut <= 1'b0;
    rdc(8'h01, {1'b0, ae, 4'h0, bo, 1'b0});
    rd(8'h03, got);
    chk("irqStatus", 32'h1, 32'(got[bo]));
    for (int i = 0; i < 128 && !bo; i++)
    begin
      a = (pg & 16'hFF80) | 16'(i);
      if (ae)
        em[{sp, a}] = 8'hFF;
      if (i[6] == pg[6] && ld[i[5:0]])
        em[{sp, a}] = ev(sp, a) & d[i[5:0]];
      crc(a, ev(sp, a));
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    chk("codeRdData", 32'hFF, 32'(codeRdData));
    for (int a = 0; a < 6; a++)
      rdc(8'(a), 8'h00);
    foreach (acc[j])
    begin
      wr(acc[j][23:16], acc[j][15:8]);
      rdc(acc[j][23:16], acc[j][7:0]);
    end
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h00, {5'h00, 2'(s), 1'b0});
      foreach (bnd[j])
        crc(bnd[j], ev(2'(s), bnd[j]));
      r = rnd();
      crc(r[15:0], ev(2'(s), r[15:0]));
    end
    for (int e = 0; e < 2; e++)
    begin
      wr(8'h02, {6'h00, 1'(e), 1'b0});
      r = rnd();
      xw(r[15:0], r[23:16]);
      chk("fwd", 32'({1'(e), ~1'(e), r[15:0], r[23:16]}), 32'(fw));
    end
    wr(8'h00, {fpm_pkg::KEY_ARM, 4'h0});
    wr(8'h04, 8'h00, 1'b1);
    wr(8'h00, {fpm_pkg::KEY_GO, 4'h0}, 1'b1);
    rdc(8'h00, 8'h00);
    wr(8'h00, {fpm_pkg::KEY_ARM, 4'h6});
    wr(8'h00, {fpm_pkg::KEY_GO, 4'h6}, 1'b1);
    rdc(8'h00, 8'h06);
    prog(2'b00, 1'b0, 1'b1, 1'b0);
    chk("irq", 32'h0, 32'(irq));
    wr(8'h04, 8'h01);
    chk("irq", 32'h1, 32'(irq));
    wr(8'h03, 8'h01);
    chk("irq", 32'h0, 32'(irq));
    prog(2'b01, 1'b1, 1'b0, 1'b0);
    prog(2'b10, 1'b0, 1'b0, 1'b0);
    prog(2'b00, 1'b1, 1'b1, 1'b0);
    prog(2'b00, 1'b0, 1'b1, 1'b1);
    close_out();
  end
endmodule  // tb
bind fpm_flash_program_mapper fpm_props chk (.clk, .reset, .regAddr, .regWrData, .regWrite,
  .execInternal, .cpuIdle, .irqDefer, .codeRdReq, .codeRdValid, .codeRdData, .xWrReq, .xWrAddr,
  .extRamWr, .intRamWr, .ramWrAddr, .arrayWrEn, .arrayEraseEn, .arrayAddr);

// ### src/fpm_flash_program_mapper.sv
// module: flash programming sequencer, page buffer and code-space mapper
// ---------------------------------------------------------------
// Functional notes
// - two control registers: space map, launch, busy status
// - internal launch holds cpu idle for whole operation
// - idle released at end; cpu resumes after triggering instruction
// - internal write: peripherals run, interrupts deferred
// - external launch leaves cpu running; busy flag polled
// - writes only clear bits; ones leave stored bits
// - erase sets whole page to FFH
// - space 00 maps user flash 0000-FFFFH, all of it programmable
// - page buffer select maps write-only page buffer
// - data-write bits 5:0 pick byte, bit 6 picks half, 15:7 pick page
// - page buffer select overrides external ram select
// - space 01: user signature 0000-01FFH, vendor 0200-027FH read-only
// - space 10: fuses 0000-007FH, security 0080-00FFH read-only; 11 reserved
// - mapped non-user space served to code reads
// - launch only on key 5 then key A, nothing between
// - busy during programming; brown-out sets error
// - 64-byte half-page buffer, cleared after each operation
// ---------------------------------------------------------------
module fpm_flash_program_mapper #(
  parameter int          BUF_DEPTH    = 64,
  parameter logic [15:0] PROG_CYCLES  = 16'h0010,
  parameter logic [15:0] ERASE_CYCLES = 16'h0040
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdData,
  // cpu status
  input  wire logic        execInternal,
  input  wire logic        instrStart,
  output logic             cpuIdle,
  output logic             irqDefer,
  output logic             irq,
  // code read port
  input  wire logic        codeRdReq,
  input  wire logic [15:0] codeRdAddr,
  output logic             codeRdValid,
  output logic      [7:0]  codeRdData,
  // data write port
  input  wire logic        xWrReq,
  input  wire logic [15:0] xWrAddr,
  input  wire logic [7:0]  xWrData,
  output logic             extRamWr,
  output logic             intRamWr,
  output logic      [15:0] ramWrAddr,
  output logic      [7:0]  ramWrData,
  // flash array port
  output logic             arrayRdEn,
  output logic      [1:0]  arrayRdSpace,
  output logic      [15:0] arrayRdAddr,
  input  wire logic [7:0]  arrayRdData,
  output logic             arrayWrEn,
  output logic             arrayEraseEn,
  output logic      [1:0]  arraySpace,
  output logic      [15:0] arrayAddr,
  output logic      [7:0]  arrayWrData,
  // supply monitor pin
  input  wire logic        brownOut
);

  localparam int IW = $clog2(BUF_DEPTH);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fpm_pkg::fpm_state_t state_reg;
  logic             pbSel_reg;
  logic [1:0]       spaceSel_reg;
  logic             autoErase_reg;
  logic             error_reg;
  logic             extRamSel_reg;
  logic [1:0]       irqStatus_reg;
  logic [1:0]       irqMask_reg;
  logic             armed_reg;
  logic             armSeen_reg;
  logic             busy_reg;
  logic             launchInt_reg;
  logic [1:0]       tSpace_reg;
  logic [8:0]       tPage_reg;
  logic             tHalf_reg;
  logic [8:0]       lastPage_reg;
  logic             lastHalf_reg;
  logic [IW-1:0]    idx_reg;
  logic [15:0]      waitCnt_reg;
  logic [7:0]       bufData_reg [BUF_DEPTH];
  logic [BUF_DEPTH-1:0] loaded_reg;
  logic             bo1_reg;
  logic             bo2_reg;
  logic             cr1Valid_reg;
  logic             cr1Blank_reg;
  logic             cr2Valid_reg;
  logic             cr2Blank_reg;

  logic             fctlWr;
  logic             launch;
  logic             abort;
  logic             doneEvt;
  logic             lastIdx;
  logic             clearBuf;
  logic             pbWrite;
  logic [15:0]      tAddr;
  logic             tWritable;
  logic             codeInRange;

  assign fctlWr = regWrite && (regAddr == fpm_pkg::OFF_FCTL);

  // ---------------------------------------------------------------
  // launch key
  // ---------------------------------------------------------------
  // a second instruction start after arming means one ran between the keys
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      armed_reg   <= 1'b0;
      armSeen_reg <= 1'b0;
    end
    else if (fctlWr)
    begin
      armed_reg   <= (regWrData[7:fpm_pkg::FCTL_KEY_LSB] == fpm_pkg::KEY_ARM);
      armSeen_reg <= 1'b0;
    end
    else if (instrStart && armed_reg)
    begin
      if (armSeen_reg)
        armed_reg <= 1'b0;
      armSeen_reg <= 1'b1;
    end
  end

  // reserved space on the go write takes no action
  assign launch = fctlWr && armed_reg && !busy_reg && !(armSeen_reg && instrStart)
                  && (regWrData[7:fpm_pkg::FCTL_KEY_LSB] == fpm_pkg::KEY_GO)
                  && (regWrData[fpm_pkg::FCTL_SPACE_HI:fpm_pkg::FCTL_SPACE_LO]
                      != fpm_pkg::SPACE_RESERVED);

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pbSel_reg     <= 1'b0;
      spaceSel_reg  <= fpm_pkg::SPACE_USER;
      autoErase_reg <= 1'b0;
      extRamSel_reg <= 1'b0;
      irqMask_reg   <= fpm_pkg::IRQ_ZERO;
    end
    else if (regWrite)
    begin
      unique case (regAddr)
        fpm_pkg::OFF_FCTL:
        begin
          pbSel_reg    <= regWrData[fpm_pkg::FCTL_PBSEL];
          spaceSel_reg <= regWrData[fpm_pkg::FCTL_SPACE_HI:fpm_pkg::FCTL_SPACE_LO];
        end
        fpm_pkg::OFF_FAUX:   autoErase_reg <= regWrData[fpm_pkg::FAUX_AUTOERASE];
        fpm_pkg::OFF_AUXCFG: extRamSel_reg <= regWrData[fpm_pkg::AUXCFG_EXTERNAL_RAM_SELECT];
        fpm_pkg::OFF_IRQMSK: irqMask_reg   <= regWrData[1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status, error and interrupt
  // ---------------------------------------------------------------
  assign doneEvt = (state_reg == fpm_pkg::ST_DONE);

  always_ff @(posedge clk)
  begin
    if (reset)
      error_reg <= 1'b0;
    else if (abort)
      error_reg <= 1'b1;
    else if (launch)
      error_reg <= 1'b0;
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      irqStatus_reg <= fpm_pkg::IRQ_ZERO;
    else
    begin
      irqStatus_reg[fpm_pkg::IRQ_DONE] <= (doneEvt && !error_reg && !abort)
        || (irqStatus_reg[fpm_pkg::IRQ_DONE]
            && !(regWrite && regAddr == fpm_pkg::OFF_IRQST
                 && regWrData[fpm_pkg::IRQ_DONE]));
      irqStatus_reg[fpm_pkg::IRQ_ERROR] <= abort
        || (irqStatus_reg[fpm_pkg::IRQ_ERROR]
            && !(regWrite && regAddr == fpm_pkg::OFF_IRQST
                 && regWrData[fpm_pkg::IRQ_ERROR]));
    end
  end

  assign irq      = |(irqStatus_reg & irqMask_reg);
  assign cpuIdle  = busy_reg && launchInt_reg;
  assign irqDefer = busy_reg && launchInt_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
      regRdData <= fpm_pkg::BYTE_ZERO;
    else if (regRead)
    begin
      regRdData <= fpm_pkg::BYTE_ZERO;
      unique case (regAddr)
        fpm_pkg::OFF_FCTL:
        begin
          regRdData[fpm_pkg::FCTL_PBSEL] <= pbSel_reg;
          regRdData[fpm_pkg::FCTL_SPACE_HI:fpm_pkg::FCTL_SPACE_LO] <= spaceSel_reg;
          regRdData[fpm_pkg::FCTL_BUSY]  <= busy_reg;
        end
        fpm_pkg::OFF_FAUX:
        begin
          regRdData[fpm_pkg::FAUX_AUTOERASE] <= autoErase_reg;
          regRdData[fpm_pkg::FAUX_ERROR]     <= error_reg;
        end
        fpm_pkg::OFF_AUXCFG: regRdData[fpm_pkg::AUXCFG_EXTERNAL_RAM_SELECT] <= extRamSel_reg;
        fpm_pkg::OFF_IRQST:  regRdData[1:0] <= irqStatus_reg;
        fpm_pkg::OFF_IRQMSK: regRdData[1:0] <= irqMask_reg;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // brown-out synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bo1_reg <= 1'b0;
      bo2_reg <= 1'b0;
    end
    else
    begin
      bo1_reg <= brownOut;
      bo2_reg <= bo1_reg;
    end
  end

  assign abort = bo2_reg && busy_reg && (state_reg != fpm_pkg::ST_DONE);

  // ---------------------------------------------------------------
  // page buffer
  // ---------------------------------------------------------------
  // an entry loads once per clear
  assign pbWrite  = xWrReq && pbSel_reg;
  assign clearBuf = doneEvt;

  genvar gi;
  generate
    for (gi = 0; gi < BUF_DEPTH; gi++)
    begin : g_entry
      always_ff @(posedge clk)
      begin
        if (reset || clearBuf)
        begin
          loaded_reg[gi]  <= 1'b0;
          bufData_reg[gi] <= fpm_pkg::BYTE_BLANK;
        end
        else if (pbWrite && !loaded_reg[gi] && (xWrAddr[IW-1:0] == IW'(gi)))
        begin
          loaded_reg[gi]  <= 1'b1;
          bufData_reg[gi] <= xWrData;
        end
      end
    end
  endgenerate

  // last buffer write address picks page and half, loaded or not
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lastPage_reg <= '0;
      lastHalf_reg <= 1'b0;
    end
    else if (pbWrite)
    begin
      lastPage_reg <= xWrAddr[15:7];
      lastHalf_reg <= xWrAddr[6];
    end
  end

  // other data writes go to data memory
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      extRamWr  <= 1'b0;
      intRamWr  <= 1'b0;
      ramWrAddr <= '0;
      ramWrData <= fpm_pkg::BYTE_ZERO;
    end
    else
    begin
      extRamWr <= xWrReq && !pbSel_reg && extRamSel_reg;
      intRamWr <= xWrReq && !pbSel_reg && !extRamSel_reg;
      if (xWrReq && !pbSel_reg)
      begin
        ramWrAddr <= xWrAddr;
        ramWrData <= xWrData;
      end
    end
  end

  // ---------------------------------------------------------------
  // programming sequencer
  // ---------------------------------------------------------------
  assign tAddr   = {tPage_reg, tHalf_reg, idx_reg};
  assign lastIdx = (idx_reg == IW'(BUF_DEPTH - 1));

  // read-only regions are never programmed
  always_comb
  begin
    unique case (tSpace_reg)
      fpm_pkg::SPACE_SIG:  tWritable = (tAddr < fpm_pkg::SIG_USER_END);
      fpm_pkg::SPACE_FUSE: tWritable = (tAddr < fpm_pkg::FUSE_USER_END);
      default:             tWritable = 1'b1;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg     <= fpm_pkg::ST_IDLE;
      busy_reg      <= 1'b0;
      launchInt_reg <= 1'b0;
      tSpace_reg    <= fpm_pkg::SPACE_USER;
      tPage_reg     <= '0;
      tHalf_reg     <= 1'b0;
      idx_reg       <= '0;
      waitCnt_reg   <= '0;
      arrayWrEn     <= 1'b0;
      arrayEraseEn  <= 1'b0;
      arraySpace    <= fpm_pkg::SPACE_USER;
      arrayAddr     <= '0;
      arrayWrData   <= fpm_pkg::BYTE_BLANK;
    end
    else
    begin
      arrayWrEn    <= 1'b0;
      arrayEraseEn <= 1'b0;
      if (abort)
        state_reg <= fpm_pkg::ST_DONE;
      else
      begin
        unique case (state_reg)
          fpm_pkg::ST_IDLE:
            if (launch)
            begin
              busy_reg      <= 1'b1;
              launchInt_reg <= execInternal;
              tSpace_reg    <= regWrData[fpm_pkg::FCTL_SPACE_HI:fpm_pkg::FCTL_SPACE_LO];
              tPage_reg     <= lastPage_reg;
              tHalf_reg     <= lastHalf_reg;
              idx_reg       <= '0;
              if (autoErase_reg)
              begin
                arrayEraseEn <= 1'b1;
                arraySpace   <= regWrData[fpm_pkg::FCTL_SPACE_HI:fpm_pkg::FCTL_SPACE_LO];
                arrayAddr    <= {lastPage_reg, 7'h00};
                waitCnt_reg  <= ERASE_CYCLES;
                state_reg    <= fpm_pkg::ST_ERASE;
              end
              else
                state_reg <= fpm_pkg::ST_SCAN;
            end
          fpm_pkg::ST_ERASE:
            if (waitCnt_reg <= 16'h0001)
              state_reg <= fpm_pkg::ST_SCAN;
            else
              waitCnt_reg <= waitCnt_reg - 16'h0001;
          fpm_pkg::ST_SCAN:
            if (loaded_reg[idx_reg] && tWritable)
              state_reg <= fpm_pkg::ST_READ;
            else if (lastIdx)
              state_reg <= fpm_pkg::ST_DONE;
            else
              idx_reg <= idx_reg + IW'(1);
          fpm_pkg::ST_READ:
            state_reg <= fpm_pkg::ST_MERGE;
          fpm_pkg::ST_MERGE:
          begin
            arrayWrEn   <= 1'b1;
            arraySpace  <= tSpace_reg;
            arrayAddr   <= tAddr;
            arrayWrData <= arrayRdData & bufData_reg[idx_reg];
            waitCnt_reg <= PROG_CYCLES;
            state_reg   <= fpm_pkg::ST_PROG;
          end
          fpm_pkg::ST_PROG:
            if (waitCnt_reg > 16'h0001)
              waitCnt_reg <= waitCnt_reg - 16'h0001;
            else if (lastIdx)
              state_reg <= fpm_pkg::ST_DONE;
            else
            begin
              idx_reg   <= idx_reg + IW'(1);
              state_reg <= fpm_pkg::ST_SCAN;
            end
          fpm_pkg::ST_DONE:
          begin
            busy_reg      <= 1'b0;
            launchInt_reg <= 1'b0;
            state_reg     <= fpm_pkg::ST_IDLE;
          end
          default: state_reg <= fpm_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // code read mapping and array read port
  // ---------------------------------------------------------------
  always_comb
  begin
    unique case (spaceSel_reg)
      fpm_pkg::SPACE_USER: codeInRange = 1'b1;
      fpm_pkg::SPACE_SIG:  codeInRange = (codeRdAddr < fpm_pkg::SIG_READ_END);
      fpm_pkg::SPACE_FUSE: codeInRange = (codeRdAddr < fpm_pkg::FUSE_READ_END);
      default:             codeInRange = 1'b0;
    endcase
  end

  // busy: sequencer owns the read port, code reads blank
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      arrayRdEn    <= 1'b0;
      arrayRdSpace <= fpm_pkg::SPACE_USER;
      arrayRdAddr  <= '0;
      cr1Valid_reg <= 1'b0;
      cr1Blank_reg <= 1'b0;
      cr2Valid_reg <= 1'b0;
      cr2Blank_reg <= 1'b0;
      codeRdValid  <= 1'b0;
      codeRdData   <= fpm_pkg::BYTE_BLANK;
    end
    else
    begin
      arrayRdEn    <= 1'b0;
      cr1Valid_reg <= codeRdReq;
      cr1Blank_reg <= busy_reg || !codeInRange;
      if (state_reg == fpm_pkg::ST_SCAN && loaded_reg[idx_reg] && tWritable && !abort)
      begin
        arrayRdEn    <= 1'b1;
        arrayRdSpace <= tSpace_reg;
        arrayRdAddr  <= tAddr;
      end
      else if (codeRdReq && !busy_reg && codeInRange)
      begin
        arrayRdEn    <= 1'b1;
        arrayRdSpace <= spaceSel_reg;
        arrayRdAddr  <= codeRdAddr;
      end
      cr2Valid_reg <= cr1Valid_reg;
      cr2Blank_reg <= cr1Blank_reg;
      codeRdValid  <= cr2Valid_reg;
      if (cr2Valid_reg)
        codeRdData <= cr2Blank_reg ? fpm_pkg::BYTE_BLANK : arrayRdData;
    end
  end

endmodule // fpm_flash_program_mapper

// ### src/fpm_pkg.sv
// package: constants and states of the flash mapper
package fpm_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_FCTL   = 8'h00;  // flash_control_reg
  localparam logic [7:0] OFF_FAUX   = 8'h01;  // flash_aux_control_reg
  localparam logic [7:0] OFF_AUXCFG = 8'h02;  // aux_config_reg
  localparam logic [7:0] OFF_IRQST  = 8'h03;
  localparam logic [7:0] OFF_IRQMSK = 8'h04;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FCTL_KEY_LSB   = 4;
  localparam int FCTL_PBSEL     = 3;
  localparam int FCTL_SPACE_HI  = 2;
  localparam int FCTL_SPACE_LO  = 1;
  localparam int FCTL_BUSY      = 0;
  localparam int FAUX_AUTOERASE = 6;
  localparam int FAUX_ERROR     = 1;
  localparam int AUXCFG_EXTERNAL_RAM_SELECT  = 1;
  localparam int IRQ_DONE       = 0;
  localparam int IRQ_ERROR      = 1;

  // ---------------------------------------------------------------
  // launch keys and space codes
  // ---------------------------------------------------------------
  localparam logic [3:0] KEY_ARM = 4'h5;
  localparam logic [3:0] KEY_GO  = 4'hA;

  localparam logic [1:0] SPACE_USER     = 2'b00;
  localparam logic [1:0] SPACE_SIG      = 2'b01;
  localparam logic [1:0] SPACE_FUSE     = 2'b10;
  localparam logic [1:0] SPACE_RESERVED = 2'b11;

  // end bounds of writable and readable regions
  localparam logic [15:0] SIG_USER_END  = 16'h0200;
  localparam logic [15:0] SIG_READ_END  = 16'h0280;
  localparam logic [15:0] FUSE_USER_END = 16'h0080;
  localparam logic [15:0] FUSE_READ_END = 16'h0100;

  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [7:0] BYTE_BLANK = 8'hFF;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [1:0] IRQ_ZERO   = 2'b00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ERASE = 3'b001,
    ST_SCAN  = 3'b010,
    ST_READ  = 3'b011,
    ST_MERGE = 3'b100,
    ST_PROG  = 3'b101,
    ST_DONE  = 3'b110
  } fpm_state_t;

endpackage
